// [src/ocp_consts.vh]
// Constants for the overcurrent fault and soft-start sequencing logic
`ifndef OCP_CONSTS_VH
`define OCP_CONSTS_VH
// Clock and oscillator discharge timing
`define CLK_PERIOD_NS 8
`define OSC_DISCHARGE_NS 170
`define OSC_DISCHARGE_CYC ((`OSC_DISCHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Calibration interval length in clock cycles
`define CAL_CYC_DEFAULT 1024
// Fault counter
`define FCNT_MAX 3'h7
`define FCNT_ZERO 3'h0
// Multiplier select codes from the low-side pin sense
`define MSEL_10K 2'h0
`define MSEL_OPEN 2'h1
`define MSEL_20K 2'h2
`define MULT_X3 4'h3
`define MULT_X7 4'h7
`define MULT_X15 4'hF
// Register byte addresses
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
// Config field positions and reset value
`define CFG_BLANK_LSB 0
`define CFG_BLANK_MSB 7
`define CFG_RESET 32'h00000010
// Status field positions
`define ST_FCNT_LSB 0
`define ST_FCNT_MSB 2
`define ST_FAULT_BIT 3
`define ST_STATE_LSB 4
`define ST_STATE_MSB 6
`define ST_MULT_LSB 8
`define ST_MULT_MSB 11
// Sequencer states
`define SEQ_IDLE 3'h0
`define SEQ_CAL 3'h1
`define SEQ_RUN 3'h2
`define SEQ_FCHG 3'h3
`define SEQ_FDIS 3'h4
`endif

// [src/in_sync3.v]
// Three-flop input synchroniser with agreement filter
module in_sync3 #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_rstn,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] level_q;
  integer k;

  // Stage one is read only by stage two; a bit moves once 2 and 3 agree
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_q <= {W{1'b0}};
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (k = 0; k < W; k = k + 1) begin
        if (s2_q[k] == s3_q[k]) begin
          level_q[k] <= s3_q[k];
        end
      end
    end
  end

  assign o_level = level_q;
endmodule

// [src/overcurrent_fault_softstart_logic.v]
// Overcurrent fault counter, oscillator off-time and soft-start sequencer
// What this block does
// - Sample low-side sense only when on, blanked
// - Over limit: count up next cycle
// - Under limit: count down, floor zero
// - Count seven: fault, both drives off
// - Multiplier three, seven or fifteen by pin
// - Latch multiplier in calibration after enable, undervoltage
// - High-side short trip: count seven, fault now
// - Short trip ends high-side pulse immediately
// - Fault holds both drives off
// - Fixed discharge interval after each ramp peak
// - PWM forced off during discharge interval
// - Soft-start starts right after calibration ends
// - Extra charge source on at soft-start
// - Extra source off at half-volt threshold
// - Fast discharge in undervoltage, calibration, low rail
// - Fault discharge by small sink only
// - Below low threshold: stop discharge, recharge
// - Pending fault: charge to high threshold first
// - Limit raised while below high threshold
`include "ocp_consts.vh"
module overcurrent_fault_softstart_logic #(
  parameter CAL_CYC = `CAL_CYC_DEFAULT,
  parameter AW = 8
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [AW-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_enable_ok,
  input wire i_uvlo_ok,
  input wire i_gate_supply_rail_ok,
  input wire i_low_side_over_limit,
  input wire i_short_circuit_trip,
  input wire i_ramp_peak,
  input wire i_pwm_on,
  input wire i_ss_above_low,
  input wire i_ss_above_half,
  input wire i_ss_above_high,
  input wire [1:0] i_multiplier_sense,
  output wire o_high_side_gate_drive,
  output wire o_low_side_gate_drive,
  output wire o_overcurrent_fault,
  output wire [3:0] o_short_circuit_multiplier,
  output wire o_limit_raised,
  output wire o_ramp_discharge,
  output wire o_ss_normal_charge,
  output wire o_ss_extra_charge,
  output wire o_ss_fast_discharge,
  output wire o_ss_sink
);
  // Counts are worked out full width, then cut to the counter widths
  localparam integer CAL_END = CAL_CYC - 1;
  localparam integer DIS_END = `OSC_DISCHARGE_CYC - 1;
  localparam [15:0] CAL_LAST = CAL_END[15:0];
  localparam [7:0] DIS_LAST = DIS_END[7:0];

  reg rst1_q;
  reg rst2_q;
  wire rstn;
  wire [11:0] sync_in;
  wire [11:0] sync_out;
  wire en_ok;
  wire uv_ok;
  wire rail_ok;
  wire ls_over;
  wire sc_trip;
  wire peak;
  wire pwm_on;
  wire ss_low;
  wire ss_half;
  wire ss_high;
  wire [1:0] msel;
  wire power_ok;

  reg [31:0] cfg_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [15:0] cal_cnt_q;
  reg [3:0] mult_q;
  reg [2:0] fcnt_q;
  reg [2:0] fcnt_d;
  reg fault_q;
  reg fault_d;
  reg peak_q;
  reg dis_q;
  reg [7:0] dis_cnt_q;
  reg cyc_start_q;
  reg hs_q;
  reg hs_d;
  reg ls_q;
  reg ls_d;
  reg [7:0] blank_q;
  reg seen_q;
  reg over_q;
  wire blank_done;
  wire switching;
  wire sc_hit;
  wire ls_sample;
  wire [31:0] status;
  wire access;

  // Release reset through two flops; assertion stays asynchronous
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst1_q <= 1'b0;
      rst2_q <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst2_q <= rst1_q;
    end
  end
  assign rstn = rst2_q;

  // Every comparator and pin level crosses in through one synchroniser
  assign sync_in = {i_multiplier_sense, i_ss_above_high, i_ss_above_half,
                    i_ss_above_low, i_pwm_on, i_ramp_peak,
                    i_short_circuit_trip, i_low_side_over_limit,
                    i_gate_supply_rail_ok, i_uvlo_ok, i_enable_ok};

  in_sync3 #(
    .W(12)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(rstn),
    .i_async(sync_in),
    .o_level(sync_out)
  );

  assign en_ok = sync_out[0];
  assign uv_ok = sync_out[1];
  assign rail_ok = sync_out[2];
  assign ls_over = sync_out[3];
  assign sc_trip = sync_out[4];
  assign peak = sync_out[5];
  assign pwm_on = sync_out[6];
  assign ss_low = sync_out[7];
  assign ss_half = sync_out[8];
  assign ss_high = sync_out[9];
  assign msel = sync_out[11:10];
  assign power_ok = en_ok & uv_ok & rail_ok;

  // Pin code to multiplier; an unused code falls back to the open value
  function [3:0] mult_decode;
    input [1:0] code;
    begin
      case (code)
        `MSEL_10K: mult_decode = `MULT_X3;
        `MSEL_20K: mult_decode = `MULT_X15;
        default: mult_decode = `MULT_X7;
      endcase
    end
  endfunction

  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      `SEQ_IDLE: begin
        if (power_ok) begin
          state_d = `SEQ_CAL;
        end
      end
      `SEQ_CAL: begin
        if (cal_cnt_q == CAL_LAST) begin
          state_d = `SEQ_RUN;
        end
      end
      `SEQ_RUN: begin
        if (fault_q) begin
          state_d = ss_high ? `SEQ_FDIS : `SEQ_FCHG;
        end
      end
      `SEQ_FCHG: begin
        if (ss_high) begin
          state_d = `SEQ_FDIS;
        end
      end
      `SEQ_FDIS: begin
        if (!ss_low) begin
          state_d = `SEQ_RUN;
        end
      end
      default: state_d = `SEQ_IDLE;
    endcase
    if (!power_ok) begin
      state_d = `SEQ_IDLE;
    end
  end

  // Sequencer state, calibration timer and latched multiplier
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= `SEQ_IDLE;
      cal_cnt_q <= 16'h0000;
      mult_q <= `MULT_X7;
    end else begin
      state_q <= state_d;
      if (state_q == `SEQ_CAL) begin
        cal_cnt_q <= cal_cnt_q + 16'h0001;
      end else begin
        cal_cnt_q <= 16'h0000;
      end
      if (state_d == `SEQ_IDLE) begin
        mult_q <= `MULT_X7;
      end else if (state_q == `SEQ_CAL && cal_cnt_q == CAL_LAST) begin
        mult_q <= mult_decode(msel);
      end
    end
  end

  // Oscillator: a ramp peak opens a fixed discharge window
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      peak_q <= 1'b0;
      dis_q <= 1'b0;
      dis_cnt_q <= 8'h00;
      cyc_start_q <= 1'b0;
    end else begin
      peak_q <= peak;
      cyc_start_q <= 1'b0;
      if (peak && !peak_q && !dis_q) begin
        dis_q <= 1'b1;
        dis_cnt_q <= 8'h00;
      end else if (dis_q) begin
        if (dis_cnt_q == DIS_LAST) begin
          dis_q <= 1'b0;
          cyc_start_q <= 1'b1; // Next ramp, next switching cycle
        end else begin
          dis_cnt_q <= dis_cnt_q + 8'h01;
        end
      end
    end
  end

  // Gate drive; switching only while charging with no fault pending
  assign switching = state_q == `SEQ_RUN && !fault_q;
  assign blank_done = blank_q >= cfg_q[`CFG_BLANK_MSB:`CFG_BLANK_LSB];
  assign sc_hit = hs_q && blank_done && sc_trip;
  assign ls_sample = ls_q && blank_done;

  // Registered drives; no overlap, one idle cycle after the high side turns off, other dead time is left to the analog driver
  always @* begin
    hs_d = 1'b0;
    ls_d = 1'b0;
    if (switching && !fault_d) begin
      hs_d = pwm_on && !dis_q && !sc_hit;
      ls_d = !hs_d && !hs_q;
    end
  end

  // Blanking counter restarts whenever either drive changes
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      blank_q <= 8'h00;
    end else begin
      hs_q <= hs_d;
      ls_q <= ls_d;
      if (hs_d != hs_q || ls_d != ls_q) begin
        blank_q <= 8'h00;
      end else if (blank_q != 8'hFF) begin
        blank_q <= blank_q + 8'h01;
      end
    end
  end

  // Fault counter and fault flag next values
  always @* begin
    fcnt_d = fcnt_q;
    fault_d = fault_q;
    if (cyc_start_q && seen_q) begin
      if (over_q) begin
        if (fcnt_q != `FCNT_MAX) begin
          fcnt_d = fcnt_q + 3'h1;
        end
      end else if (fcnt_q != `FCNT_ZERO) begin
        fcnt_d = fcnt_q - 3'h1;
      end
    end
    if (fcnt_d == `FCNT_MAX) begin
      fault_d = 1'b1;
    end
    if (sc_hit) begin
      fcnt_d = `FCNT_MAX;
      fault_d = 1'b1;
    end
    if (state_q == `SEQ_FDIS && state_d == `SEQ_RUN) begin
      fcnt_d = `FCNT_ZERO;
      fault_d = 1'b0;
    end
    if (state_d == `SEQ_IDLE || state_q == `SEQ_CAL) begin
      fcnt_d = `FCNT_ZERO;
      fault_d = 1'b0;
    end
  end

  // Per-cycle sample memory, consumed at the next cycle start
  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      fcnt_q <= `FCNT_ZERO;
      fault_q <= 1'b0;
      seen_q <= 1'b0;
      over_q <= 1'b0;
    end else begin
      fcnt_q <= fcnt_d;
      fault_q <= fault_d;
      if (cyc_start_q) begin
        seen_q <= ls_sample; // A sample on the start edge is not lost
        over_q <= ls_sample && ls_over;
      end else if (ls_sample) begin
        seen_q <= 1'b1;
        over_q <= over_q | ls_over;
      end
    end
  end

  // Soft-start node controls
  assign o_ss_fast_discharge = state_q == `SEQ_IDLE ||
                               state_q == `SEQ_CAL;
  assign o_ss_sink = state_q == `SEQ_FDIS;
  assign o_ss_normal_charge = state_q == `SEQ_RUN ||
                              state_q == `SEQ_FCHG;
  assign o_ss_extra_charge = o_ss_normal_charge && !ss_half;
  // Raised limit while the node is below the high threshold
  assign o_limit_raised = !ss_high;

  // APB slave: zero wait states, error on unmapped address
  assign access = i_psel && i_penable;
  assign status = {20'h00000, mult_q, 1'b0, state_q, fault_q, fcnt_q};

  always @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= `CFG_RESET;
    end else if (access && i_pwrite && i_paddr == `REG_CONFIG) begin
      cfg_q <= {24'h000000, i_pwdata[`CFG_BLANK_MSB:`CFG_BLANK_LSB]};
    end
  end

  assign o_pready = 1'b1;
  assign o_pslverr = access && i_paddr != `REG_CONFIG &&
                     i_paddr != `REG_STATUS;
  assign o_prdata = (i_paddr == `REG_CONFIG) ? cfg_q :
                    (i_paddr == `REG_STATUS) ? status : 32'h00000000;

  // Outputs to drivers and analog side
  assign o_high_side_gate_drive = hs_q;
  assign o_low_side_gate_drive = ls_q;
  assign o_overcurrent_fault = fault_q;
  assign o_short_circuit_multiplier = mult_q;
  assign o_ramp_discharge = dis_q;
endmodule

// [verification/ocp_monitor.sv]
// Port checker for the fault counter and soft-start sequencer
module ocp_monitor (
  input wire i_clk,
  input wire i_rstn,
  input wire i_short_circuit_trip,
  input wire i_uvlo_ok,
  input wire i_enable_ok,
  input wire i_ss_above_half,
  input wire i_ss_above_high,
  input wire o_high_side_gate_drive,
  input wire o_low_side_gate_drive,
  input wire o_overcurrent_fault,
  input wire [3:0] o_short_circuit_multiplier,
  input wire o_limit_raised,
  input wire o_ramp_discharge,
  input wire o_ss_extra_charge,
  input wire o_ss_fast_discharge,
  input wire o_ss_sink
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dcnt_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Length of the running discharge window, so its width can be judged
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) dcnt_q <= 8'h00;
    else if (o_ramp_discharge) dcnt_q <= dcnt_q + 8'h01;
    else dcnt_q <= 8'h00;
  end
  property p_fault_off;
    o_overcurrent_fault |-> !o_high_side_gate_drive && !o_low_side_gate_drive;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("drive during fault");
  property p_disc_len;
    $fell(o_ramp_discharge) |-> dcnt_q == 8'h16;
  endproperty
  a_disc_len: assert property (p_disc_len) else $error("discharge width");
  property p_disc_off;
    o_ramp_discharge && $past(o_ramp_discharge) |-> !o_high_side_gate_drive;
  endproperty
  a_disc_off: assert property (p_disc_off) else $error("pwm in off-time");
  // Bound covers blanking plus the input filter latency
  property p_sc_cut;
    i_short_circuit_trip && o_high_side_gate_drive |->
      ##[1:24] !o_high_side_gate_drive;
  endproperty
  a_sc_cut: assert property (p_sc_cut) else $error("high side not cut");
  property p_sc_fault;
    i_short_circuit_trip && o_high_side_gate_drive |->
      ##[1:24] o_overcurrent_fault;
  endproperty
  a_sc_fault: assert property (p_sc_fault) else $error("no short fault");
  property p_mult;
    o_short_circuit_multiplier == 4'h3 || o_short_circuit_multiplier == 4'h7
      || o_short_circuit_multiplier == 4'hF;
  endproperty
  a_mult: assert property (p_mult) else $error("bad multiplier");
  property p_uv_fast;
    !i_uvlo_ok [*8] |-> o_ss_fast_discharge;
  endproperty
  a_uv_fast: assert property (p_uv_fast) else $error("no fast discharge");
  property p_off_idle;
    !i_enable_ok [*8] |-> !o_overcurrent_fault && !o_ss_sink;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("not idle");
  property p_half;
    i_ss_above_half [*8] |-> !o_ss_extra_charge;
  endproperty
  a_half: assert property (p_half) else $error("extra source on");
  property p_raise;
    !i_ss_above_high [*8] |-> o_limit_raised;
  endproperty
  a_raise: assert property (p_raise) else $error("limit not raised");
  c_fault: cover property ($rose(o_overcurrent_fault));
  c_sink: cover property (o_ss_sink);
  c_extra: cover property (o_ss_extra_charge);
endmodule
bind overcurrent_fault_softstart_logic ocp_monitor i_ocp_monitor (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_short_circuit_trip(i_short_circuit_trip),
  .i_uvlo_ok(i_uvlo_ok), .i_enable_ok(i_enable_ok),
  .i_ss_above_half(i_ss_above_half), .i_ss_above_high(i_ss_above_high),
  .o_high_side_gate_drive(o_high_side_gate_drive),
  .o_low_side_gate_drive(o_low_side_gate_drive),
  .o_overcurrent_fault(o_overcurrent_fault),
  .o_short_circuit_multiplier(o_short_circuit_multiplier),
  .o_limit_raised(o_limit_raised), .o_ramp_discharge(o_ramp_discharge),
  .o_ss_extra_charge(o_ss_extra_charge),
  .o_ss_fast_discharge(o_ss_fast_discharge), .o_ss_sink(o_ss_sink));

// [verification/power_stage_model.sv]
// Gate drivers, sense comparators and soft-start node stand-in
module power_stage_model (
  input wire i_clk,
  input wire i_hs,
  input wire i_ls,
  input wire i_chg,
  input wire i_xchg,
  input wire i_fdis,
  input wire i_sink,
  input wire i_sc_cmd,
  input wire i_ov_cmd,
  output wire o_low,
  output wire o_half,
  output wire o_high,
  output wire o_sc_trip,
  output wire o_ov
);
  timeunit 1ns;
  timeprecision 1ps;
  int lvl = 0;
  // Node level in coarse steps; it clamps like a node tied to the supply
  // Tracking input counts as tied high, so the output follows this node
  always @(posedge i_clk) begin
    if (i_fdis) lvl <= 0;
    else if (i_sink) lvl <= (lvl > 0) ? lvl - 1 : 0;
    else if (lvl < 300) lvl <= lvl + (i_chg ? 2 : 0) + (i_xchg ? 6 : 0);
  end
  assign o_low = lvl > 30;
  assign o_half = lvl > 50;
  assign o_high = lvl > 250;
  // A comparator only sees current while its own FET conducts
  assign o_sc_trip = i_sc_cmd && i_hs;
  assign o_ov = i_ov_cmd && i_ls;
endmodule

// [verification/overcurrent_fault_softstart_logic_tb_top.sv]
// Self-checking bench for the fault counter and soft-start block
`include "ocp_consts.vh"
module overcurrent_fault_softstart_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic en = 0, uv = 1, rail = 1, peak = 0, pwm = 0, sc_cmd = 0, ov_cmd = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0] msel = 2'h1;
  logic [5:0] rc = 6'h00;
  logic [1:0] cs [4] = '{2'h3, `MSEL_OPEN, `MSEL_20K, `MSEL_10K};
  logic [3:0] ms [4] = '{4'h7, `MULT_X7, `MULT_X15, `MULT_X3};
  wire [31:0] prdata;
  wire [3:0] mult;
  wire pready, pslverr, hs, ls, flt, lraise, rdis, nchg, xchg, fdis, sink;
  wire sa_lo, sa_hf, sa_hi, sct, ovl;
  int fail_count = 0, samples_checked = 0;
  overcurrent_fault_softstart_logic #(.CAL_CYC(16))
    i_overcurrent_fault_softstart_logic (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_enable_ok(en), .i_uvlo_ok(uv), .i_gate_supply_rail_ok(rail),
    .i_low_side_over_limit(ovl), .i_short_circuit_trip(sct),
    .i_ramp_peak(peak), .i_pwm_on(pwm), .i_ss_above_low(sa_lo),
    .i_ss_above_half(sa_hf), .i_ss_above_high(sa_hi),
    .i_multiplier_sense(msel), .o_high_side_gate_drive(hs),
    .o_low_side_gate_drive(ls), .o_overcurrent_fault(flt),
    .o_short_circuit_multiplier(mult), .o_limit_raised(lraise),
    .o_ramp_discharge(rdis), .o_ss_normal_charge(nchg),
    .o_ss_extra_charge(xchg), .o_ss_fast_discharge(fdis), .o_ss_sink(sink));
  power_stage_model i_power_stage_model (
    .i_clk(clk), .i_hs(hs), .i_ls(ls), .i_chg(nchg), .i_xchg(xchg),
    .i_fdis(fdis), .i_sink(sink), .i_sc_cmd(sc_cmd), .i_ov_cmd(ov_cmd),
    .o_low(sa_lo), .o_half(sa_hf), .o_high(sa_hi), .o_sc_trip(sct),
    .o_ov(ovl));
  initial forever #4 clk = ~clk;
  // Oscillator: peak held 8 cycles so the input filter sees it
  always @(posedge clk) begin
    rc <= rc + 6'h01;
    peak <= rc[5:3] == 3'h7;
    pwm <= rc < 6'h28;
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer; data is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t bus transfer ran out", $time);
      stop_test();
    end
  endtask
  // Poll status until the masked bits match, with a bounded count
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v,
    input int b);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      apb(0, `REG_STATUS, 32'h0, q, e);
      n++;
    end while ((q & m) !== v && n < b);
    if (n >= b) begin
      fail_count++;
      $display("[ERR] %0t status wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(0, `REG_CONFIG, 32'h0, q, e);
    chk(q, `CFG_RESET);
    apb(1, `REG_CONFIG, 32'h00000004, q, e);
    apb(0, `REG_CONFIG, 32'h0, q, e);
    chk(q, 32'h00000004);
    apb(1, `REG_STATUS, 32'h000000FF, q, e);
    apb(0, `REG_STATUS, 32'h0, q, e);
    chk(q, 32'h00000700);
    apb(0, 8'h08, 32'h0, q, e);
    chk(q | {31'h0, e}, 32'h00000001);
    $display("t_regs done");
  endtask
  task automatic t_start(input logic [1:0] c, input logic [3:0] m);
    en <= 0;
    repeat (12) @(posedge clk);
    msel <= c;
    en <= 1;
    wait_st(32'h70, 32'h10, 20);
    chk(fdis, 1);
    wait_st(32'h70, 32'h20, 20);
    chk(mult, m);
    chk({nchg, xchg}, 2'b11);
    $display("t_start done");
  endtask
  task automatic t_sc();
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    // Trip at the start of a full pulse, so it outlasts blanking and filter
    while (ls !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    while (hs !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      $display("[ERR] %0t no high-side pulse", $time);
      stop_test();
    end
    sc_cmd <= 1;
    wait_st(32'h8, 32'h8, 20);
    sc_cmd <= 0;
    chk({hs, ls}, 0);
    apb(0, `REG_STATUS, 32'h0, q, e);
    chk(q[6:0], 7'h3F);
    wait_st(32'h70, 32'h40, 300);
    chk({sink, fdis}, 2'b10);
    wait_st(32'h7F, 32'h20, 400);
    $display("t_sc done");
  endtask
  task automatic t_ocp();
    logic [31:0] q;
    logic e;
    // Count up a little, then let it run down and rest on zero
    ov_cmd <= 1;
    wait_st(32'h7, 32'h2, 200);
    ov_cmd <= 0;
    wait_st(32'h7, 32'h1, 200);
    wait_st(32'h7, 32'h0, 200);
    repeat (70) @(posedge clk);
    apb(0, `REG_STATUS, 32'h0, q, e);
    chk(q[3:0], 4'h0);
    ov_cmd <= 1;
    wait_st(32'hF, 32'hF, 400);
    ov_cmd <= 0;
    chk({hs, ls}, 0);
    wait_st(32'h7F, 32'h20, 600);
    $display("t_ocp done");
  endtask
  task automatic t_off();
    logic [31:0] q;
    logic e;
    uv <= 0;
    repeat (12) @(posedge clk);
    apb(0, `REG_STATUS, 32'h0, q, e);
    chk(q[6:0], 7'h00);
    chk(fdis, 1);
    $display("t_off done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    t_regs();
    for (int i = 0; i < 4; i++) t_start(cs[i], ms[i]);
    t_sc();
    t_ocp();
    t_off();
    stop_test();
  end
endmodule
